// [design/rxcfg_defines.vh]
// Offsets, field positions, reset values and timing counts for the receiver config bank
`ifndef RXCFG_DEFINES_VH
`define RXCFG_DEFINES_VH
`define RXCFG_ADDR_W           6
`define RXCFG_OFS_CHAN_FILT    6'h0A
`define RXCFG_OFS_AGC_SQ       6'h0B
`define RXCFG_OFS_FIRST_GAIN   6'h0C
`define RXCFG_OFS_LATER_GAIN   6'h0D
`define RXCFG_RST_CHAN_FILT    8'h00
`define RXCFG_RST_AGC_SQ       8'h1A
`define RXCFG_RST_FIRST_GAIN   8'hD8
`define RXCFG_RST_LATER_GAIN   8'h00
`define RXCFG_BIT_CHAN_CHOICE  7
`define RXCFG_BIT_AMD_MIXER    6
`define RXCFG_BIT_LOW_POWER    7
`define RXCFG_BIT_LF_SPLIT     6
`define RXCFG_BIT_LF_ENABLE    5
`define RXCFG_BIT_AGC_EN       4
`define RXCFG_BIT_AGC_WHOLE    3
`define RXCFG_BIT_AGC_RESET    2
`define RXCFG_BIT_SQ_DYN       1
`define RXCFG_BIT_PMIX_INT     0
`define RXCFG_BIT_CLIP         1
`define RXCFG_BIT_PEER_CUT     0
`define RXCFG_GAIN_MAX         4'hA
`define RXCFG_SQ_DELAY_NS      18880
`define RXCFG_CLK_NS           4
`define RXCFG_SQ_DELAY_CYC     (`RXCFG_SQ_DELAY_NS / `RXCFG_CLK_NS)
`define RXCFG_FC_STEP          64
`endif

// [design/rxcfg_regs.v]
// Receiver configuration register bank with derived receive-chain controls
//
// Overview of operation
// [R1] Single enabled channel: choice bit 0 picks AM, 1 picks PM.
// [R2] Both channels, manual selection: choice bit picks framing source channel.
// [R3] AM demodulator: 0 peak detector, 1 mixer.
// [R4] Low power receive bit selects low power mode; resets to 0.
// [R5] LF split 0 differential, 1 RFI1 to AM, RFI2 to PM; separate enable.
// [R6] AGC active while its enable bit is 1, reset value 1.
// [R7] AGC window: 0 first eight sub-carrier pulses, 1 whole receive.
// [R8] AGC algorithm: 0 preset based, 1 reset based.
// [R9] Dynamic squelch starts 18.88 us after Tx end, ends at mask expiry.
// [R10] PM mixer clock: 0 RFO, 1 internal; single mode forces internal.
// [R11] First stage gain code: 0 full, 1-6 minus 2.5 dB steps, 7 boost.
// [R12] Clip bit clips first and second stage output to 0.6 V.
// [R13] Peer gain cut forces -6 dB later stages and widest comparator window.
// [R14] Host restarts receiver after clearing peer gain cut.
// [R15] Later stage gain codes 0h..Ah only; codes above Ah are clamped.
// [R16] Later stage gain reaches AGC/squelch/RSSI only on reset-gain command.
// [R17] All four registers reload defaults at reset and set-default command.
// [R18] Mask timer counts 64 carrier periods per step from Tx end.
// [R19] Each register is 8-bit read-write returning last written value.
//
// Usage notes
// Register port has no wait states; read data stands only in the cycle
// after the read strobe and is zero in every other cycle.
// Set-default beats a write to the same register in the same cycle, so a
// write issued alongside the command is lost.
// Unmapped addresses ignore writes and read back as zero.
// Decoded controls follow the registers one clock later; software sees no
// difference, but a checker must allow for that cycle.
// Later-stage gain outputs hold until the reset-gain command, even across
// set-default; a new register value waits for that command.
// Codes above Ah in the later-stage nibbles are clamped on load rather than
// passed on, keeping the digitizer window inside its defined range.
// Clearing the peer gain cut retriggers nothing here; the host must restart
// the receiver before trusting received data.
// Squelch samples the dynamic enable bit at end of transmission only;
// clearing it mid-sequence does not abort a squelch already under way.
// A mask timer that expires before the squelch delay ends skips squelch.
// Squelch delay and mask step are parameters so simulation can shorten
// them; defaults are the documented values.
// One clock domain; all context inputs are taken as synchronous.
// Channel enables pass through unless exactly one channel is on.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "rxcfg_defines.vh"

module rxcfg_regs #(
  parameter SQ_DELAY_CYC = `RXCFG_SQ_DELAY_CYC,
  parameter FC_STEP      = `RXCFG_FC_STEP
) (
  // Clock and reset
  input  wire                      clk_sys,
  input  wire                      rst_b,
  // Register port
  input  wire [`RXCFG_ADDR_W-1:0]  reg_addr,
  input  wire [7:0]                reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [7:0]                reg_rdata,
  // Commands and receive-chain context
  input  wire                      cmd_set_default,
  input  wire                      cmd_reset_rx_gain,
  input  wire                      am_rx_on,
  input  wire                      pm_rx_on,
  input  wire                      manual_chan_sel,
  input  wire                      single_mode,
  input  wire                      tx_end,
  input  wire                      fc_tick,
  input  wire [7:0]                mask_rx_time,
  // Channel and filter controls
  output reg                       am_chan_en,
  output reg                       pm_chan_en,
  output reg                       framing_from_pm,
  output reg                       amd_mixer,
  output reg  [2:0]                lowpass_ctrl,
  output reg  [2:0]                zero_setting,
  // Input routing and AGC
  output reg                       low_power_receive,
  output reg                       lf_input_split,
  output reg                       lf_input_enable,
  output reg                       agc_active,
  output reg                       agc_whole_period,
  output reg                       agc_reset_alg,
  output reg                       pm_mixer_clock_src,
  // Gains
  output reg  [2:0]                am_first_gain,
  output reg  [2:0]                pm_first_gain,
  output reg                       gain_clip,
  output reg                       forced_peer_gain_cut,
  output reg                       max_comp_window,
  output reg  [3:0]                am_later_gain,
  output reg  [3:0]                pm_later_gain,
  // Squelch and masking
  output reg                       squelch_on,
  output reg                       rx_masked
);

  // Squelch sequencer states
  localparam ST_IDLE  = 3'b001;
  localparam ST_DELAY = 3'b010;
  localparam ST_SQ    = 3'b100;

  // Software-visible configuration registers
  reg [7:0]  chan_filt_q;
  reg [7:0]  agc_sq_q;
  reg [7:0]  first_gain_q;
  reg [7:0]  later_gain_q;
  // Squelch sequencer state and delay count
  reg [2:0]  state_q;
  reg [2:0]  state_d;
  reg [15:0] dly_q;
  // Mask receive timer
  reg [7:0]  mask_cnt_q;
  reg [7:0]  step_q;
  reg        mask_run_q;

  // Write decode per register
  wire wr_chan  = reg_wr && (reg_addr == `RXCFG_OFS_CHAN_FILT);
  wire wr_agc   = reg_wr && (reg_addr == `RXCFG_OFS_AGC_SQ);
  wire wr_first = reg_wr && (reg_addr == `RXCFG_OFS_FIRST_GAIN);
  wire wr_later = reg_wr && (reg_addr == `RXCFG_OFS_LATER_GAIN);
  // Mask timer reached zero while running
  wire mask_exp = mask_run_q && (mask_cnt_q == 8'h00);

  // Clamp a later-stage gain code to the usable range
  function [3:0] clamp_gain;
    input [3:0] code;
    begin
      clamp_gain = (code > `RXCFG_GAIN_MAX) ? `RXCFG_GAIN_MAX : code;
    end
  endfunction

  // Register storage, defaults on reset and set-default
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      chan_filt_q  <= `RXCFG_RST_CHAN_FILT;
      agc_sq_q     <= `RXCFG_RST_AGC_SQ;
      first_gain_q <= `RXCFG_RST_FIRST_GAIN;
      later_gain_q <= `RXCFG_RST_LATER_GAIN;
    end else if (cmd_set_default) begin // [R17]
      // Default load wins over a same-cycle write
      chan_filt_q  <= `RXCFG_RST_CHAN_FILT;
      agc_sq_q     <= `RXCFG_RST_AGC_SQ;
      first_gain_q <= `RXCFG_RST_FIRST_GAIN;
      later_gain_q <= `RXCFG_RST_LATER_GAIN;
    end else begin
      if (wr_chan)  chan_filt_q  <= reg_wdata; // [R19]
      if (wr_agc)   agc_sq_q     <= reg_wdata; // [R19]
      if (wr_first) first_gain_q <= reg_wdata; // [R19]
      if (wr_later) later_gain_q <= reg_wdata; // [R19]
    end
  end

  // Read data one cycle after the strobe, zero elsewhere
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `RXCFG_OFS_CHAN_FILT:  reg_rdata <= chan_filt_q; // [R19]
        `RXCFG_OFS_AGC_SQ:     reg_rdata <= agc_sq_q;
        `RXCFG_OFS_FIRST_GAIN: reg_rdata <= first_gain_q;
        `RXCFG_OFS_LATER_GAIN: reg_rdata <= later_gain_q;
        // Unmapped addresses read zero
        default:               reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Static decoded controls
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      am_chan_en           <= 1'b0;
      pm_chan_en           <= 1'b0;
      framing_from_pm      <= 1'b0;
      amd_mixer            <= 1'b0;
      lowpass_ctrl         <= 3'h0;
      zero_setting         <= 3'h0;
      low_power_receive    <= 1'b0;
      lf_input_split       <= 1'b0;
      lf_input_enable      <= 1'b0;
      agc_active           <= 1'b0;
      agc_whole_period     <= 1'b0;
      agc_reset_alg        <= 1'b0;
      pm_mixer_clock_src   <= 1'b0;
      am_first_gain        <= 3'h0;
      pm_first_gain        <= 3'h0;
      gain_clip            <= 1'b0;
      forced_peer_gain_cut <= 1'b0;
      max_comp_window      <= 1'b0;
    end else begin
      // Only one channel on: choice bit enables it
      if (am_rx_on ^ pm_rx_on) begin
        am_chan_en <= ~chan_filt_q[`RXCFG_BIT_CHAN_CHOICE]; // [R1]
        pm_chan_en <= chan_filt_q[`RXCFG_BIT_CHAN_CHOICE];  // [R1]
      end else begin
        am_chan_en <= am_rx_on;
        pm_chan_en <= pm_rx_on;
      end
      // Framing source under manual selection, else the lone PM channel
      if (am_rx_on && pm_rx_on && manual_chan_sel)
        framing_from_pm <= chan_filt_q[`RXCFG_BIT_CHAN_CHOICE]; // [R2]
      else
        framing_from_pm <= (am_rx_on ^ pm_rx_on) & chan_filt_q[`RXCFG_BIT_CHAN_CHOICE];
      // Channel and filter register fields
      amd_mixer          <= chan_filt_q[`RXCFG_BIT_AMD_MIXER]; // [R3]
      lowpass_ctrl       <= chan_filt_q[5:3];
      zero_setting       <= chan_filt_q[2:0];
      // AGC and squelch register fields
      low_power_receive  <= agc_sq_q[`RXCFG_BIT_LOW_POWER]; // [R4]
      lf_input_split     <= agc_sq_q[`RXCFG_BIT_LF_SPLIT];  // [R5]
      lf_input_enable    <= agc_sq_q[`RXCFG_BIT_LF_ENABLE]; // [R5]
      agc_active         <= agc_sq_q[`RXCFG_BIT_AGC_EN];    // [R6]
      agc_whole_period   <= agc_sq_q[`RXCFG_BIT_AGC_WHOLE]; // [R7]
      agc_reset_alg      <= agc_sq_q[`RXCFG_BIT_AGC_RESET]; // [R8]
      pm_mixer_clock_src <= single_mode | agc_sq_q[`RXCFG_BIT_PMIX_INT]; // [R10]
      // First stage gain register fields
      am_first_gain      <= first_gain_q[7:5]; // [R11]
      pm_first_gain      <= first_gain_q[4:2]; // [R11]
      gain_clip          <= first_gain_q[`RXCFG_BIT_CLIP]; // [R12]
      forced_peer_gain_cut <= first_gain_q[`RXCFG_BIT_PEER_CUT]; // [R13]
      max_comp_window    <= first_gain_q[`RXCFG_BIT_PEER_CUT];   // [R13]
    end
  end

  // Later-stage gain loads only on the reset-gain command
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      am_later_gain <= 4'h0;
      pm_later_gain <= 4'h0;
    end else if (cmd_reset_rx_gain) begin // [R16]
      // Clamp keeps codes inside the defined range
      am_later_gain <= clamp_gain(later_gain_q[7:4]); // [R15]
      pm_later_gain <= clamp_gain(later_gain_q[3:0]); // [R15]
    end
  end

  // Mask receive timer, one step per FC_STEP carrier ticks
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mask_run_q <= 1'b0;
      mask_cnt_q <= 8'h00;
      step_q     <= 8'h00;
      rx_masked  <= 1'b0;
    end else if (tx_end) begin // [R18]
      // Reload the count and raise the mask
      mask_run_q <= 1'b1;
      mask_cnt_q <= mask_rx_time;
      step_q     <= 8'h00;
      rx_masked  <= 1'b1;
    end else if (mask_exp) begin
      // Expiry releases the mask
      mask_run_q <= 1'b0;
      rx_masked  <= 1'b0;
    end else if (mask_run_q && fc_tick) begin
      // Count carrier ticks into timer steps
      if (step_q == FC_STEP[7:0] - 8'h01) begin // [R18]
        step_q     <= 8'h00;
        mask_cnt_q <= mask_cnt_q - 8'h01;
      end else begin
        step_q <= step_q + 8'h01;
      end
    end
  end

  // Squelch sequencer next state
  always @* begin
    state_d = state_q;
    case (state_q)
      // Idle leaves only on end of Tx with dynamic squelch on
      ST_IDLE:  if (tx_end && agc_sq_q[`RXCFG_BIT_SQ_DYN]) state_d = ST_DELAY; // [R9]
      // Expiry during the delay skips squelch
      ST_DELAY: if (mask_exp) state_d = ST_IDLE;
                else if (dly_q == SQ_DELAY_CYC[15:0] - 16'h0001) state_d = ST_SQ; // [R9]
      // Squelch lasts until the mask timer expires
      ST_SQ:    if (mask_exp) state_d = ST_IDLE; // [R9]
      default:  state_d = ST_IDLE;
    endcase
  end

  // Squelch sequencer registers
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= ST_IDLE;
      dly_q      <= 16'h0000;
      squelch_on <= 1'b0;
    end else begin
      state_q    <= state_d;
      // Delay counter runs only in the delay state
      dly_q      <= (state_q == ST_DELAY) ? dly_q + 16'h0001 : 16'h0000;
      squelch_on <= (state_d == ST_SQ);
    end
  end

endmodule // rxcfg_regs

// [test/rxcfg_regs_chk_properties.sv]
// Port-level checks for the receiver config bank
`timescale 1ns/1ps
`include "rxcfg_defines.vh"
module rxcfg_regs_chk (
  // Clock and reset
  input wire                     clk_sys,
  input wire                     rst_b,
  // Register port
  input wire [`RXCFG_ADDR_W-1:0] reg_addr,
  input wire [7:0]               reg_wdata,
  input wire                     reg_wr,
  input wire                     reg_rd,
  input wire [7:0]               reg_rdata,
  // Commands and context
  input wire                     cmd_set_default,
  input wire                     cmd_reset_rx_gain,
  input wire                     am_rx_on,
  input wire                     pm_rx_on,
  input wire                     single_mode,
  // Decoded controls
  input wire                     am_chan_en,
  input wire                     pm_chan_en,
  input wire                     pm_mixer_clock_src,
  input wire                     forced_peer_gain_cut,
  input wire                     max_comp_window,
  input wire [3:0]               am_later_gain,
  input wire [3:0]               pm_later_gain,
  input wire                     squelch_on,
  input wire                     rx_masked
);
  // All checks share the system clock and reset
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  chk_read_back: assert property ((reg_wr && !cmd_set_default && reg_addr >= 6'h0A &&
    reg_addr <= 6'h0D) ##1 (reg_rd && reg_addr == $past(reg_addr) && !cmd_set_default)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("read back differs from write");
  chk_default_load: assert property ((cmd_set_default ##1 (reg_rd && reg_addr == 6'h0C &&
    !cmd_set_default)) |=> reg_rdata == 8'hD8) else $error("default not loaded");
  chk_gain_clamp: assert property (cmd_reset_rx_gain |=>
    am_later_gain <= 4'hA && pm_later_gain <= 4'hA) else $error("later gain above Ah");
  chk_gain_hold: assert property ((reg_wr && !cmd_reset_rx_gain && !cmd_set_default &&
    !$past(cmd_set_default)) |=> $stable(am_later_gain) && $stable(pm_later_gain))
    else $error("later gain moved without load");
  chk_single_chan: assert property ((am_rx_on ^ pm_rx_on) [*2] |->
    (am_chan_en ^ pm_chan_en)) else $error("single channel not exclusive");
  chk_pmix_single: assert property (single_mode [*2] |-> pm_mixer_clock_src)
    else $error("single mode not using internal clock");
  chk_peer_window: assert property (forced_peer_gain_cut |-> max_comp_window)
    else $error("peer cut without wide window");
  chk_squelch_mask: assert property ($rose(squelch_on) |-> rx_masked)
    else $error("squelch started after mask expiry");
endmodule // rxcfg_regs_chk

bind rxcfg_regs rxcfg_regs_chk u_chk (.*);

// [test/rxcfg_regs_bench.sv]
// Self-checking bench for the receiver config bank
`timescale 1ns/1ps
`include "rxcfg_defines.vh"
module rxcfg_regs_bench;
  logic clk_sys, rst_b, reg_wr, reg_rd, cmd_set_default, cmd_reset_rx_gain;
  logic am_rx_on, pm_rx_on, manual_chan_sel, single_mode, tx_end, fc_tick;
  logic [`RXCFG_ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, mask_rx_time;
  logic am_chan_en, pm_chan_en, framing_from_pm, amd_mixer, low_power_receive;
  logic lf_input_split, lf_input_enable, agc_active, agc_whole_period, agc_reset_alg;
  logic pm_mixer_clock_src, gain_clip, forced_peer_gain_cut, max_comp_window;
  logic squelch_on, rx_masked;
  logic [2:0] lowpass_ctrl, zero_setting, am_first_gain, pm_first_gain;
  logic [3:0] am_later_gain, pm_later_gain;
  logic [5:0] ofs [4] = '{6'h0A, 6'h0B, 6'h0C, 6'h0D};
  logic [7:0] dflt [4] = '{`RXCFG_RST_CHAN_FILT, `RXCFG_RST_AGC_SQ,
                           `RXCFG_RST_FIRST_GAIN, `RXCFG_RST_LATER_GAIN};
  logic [7:0] pat [4] = '{8'h6B, 8'hE4, 8'h27, 8'h5C};
  int error_cnt = 0;
  int checks_done = 0;
  // Short squelch delay and mask step keep the run brief
  rxcfg_regs #(.SQ_DELAY_CYC(10), .FC_STEP(4)) uut (.*);
  // 250 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      $display("[FAIL] %0t %s", $time, msg);
      error_cnt++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys) reg_wr <= 1'b0;
    #1;
  endtask
  // Write strobe stays up for back-to-back writes; next access drops it
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata === exp, "read data");
  endtask
  task automatic pulse_gain;
    @(posedge clk_sys);
    cmd_reset_rx_gain <= 1'b1;
    @(posedge clk_sys);
    cmd_reset_rx_gain <= 1'b0;
    #1;
  endtask
  task automatic pulse_txend;
    @(posedge clk_sys);
    tx_end <= 1'b1;
    @(posedge clk_sys);
    tx_end <= 1'b0;
    #1;
  endtask
  task automatic t_rw;
    logic [7:0] q [4];
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 4; i++) q[i] = pat[i] ^ (k == 0 ? 8'hFF : 8'h00);
      for (int i = 0; i < 4; i++) begin
        wr(ofs[i], q[i]);
        rd(ofs[i], q[i]);
      end
      tick(2);
      check(amd_mixer === q[0][6] && {lowpass_ctrl, zero_setting} === q[0][5:0], "cfg1");
      check({low_power_receive, lf_input_split, lf_input_enable} === q[1][7:5], "cfg2a");
      check({agc_active, agc_whole_period, agc_reset_alg} === q[1][4:2], "agc");
      check(pm_mixer_clock_src === q[1][0], "pm mixer clock");
      check({am_first_gain, pm_first_gain, gain_clip} === q[2][7:1], "first gain");
      check(forced_peer_gain_cut === q[2][0] && max_comp_window === q[2][0], "peer cut");
      check(am_later_gain === 4'h0 && pm_later_gain === 4'h0, "gain loaded early");
    end
    single_mode <= 1'b1;
    tick(3);
    check(pm_mixer_clock_src === 1'b1, "single mode clock");
    wr(6'h0E, 8'hFF);
    rd(6'h0E, 8'h00);
    $display("test rw done");
  endtask
  task automatic t_chan;
    for (int c = 0; c < 2; c++) begin
      wr(6'h0A, c ? 8'h80 : 8'h00);
      {am_rx_on, pm_rx_on, manual_chan_sel} <= 3'b101;
      tick(3);
      check(pm_chan_en === c[0] && am_chan_en === !c[0], "single channel");
      pm_rx_on <= 1'b1;
      tick(3);
      check(framing_from_pm === c[0], "framing source");
    end
    $display("test chan done");
  endtask
  task automatic t_gain;
    wr(6'h0D, 8'h7F);
    tick(1);
    pulse_gain();
    check(am_later_gain === 4'h7 && pm_later_gain === 4'hA, "gain load 7F");
    wr(6'h0D, 8'hA3);
    tick(1);
    pulse_gain();
    check(am_later_gain === 4'hA && pm_later_gain === 4'h3, "gain load A3");
    wr(6'h0C, 8'hD9);
    tick(2);
    check(forced_peer_gain_cut === 1'b1 && max_comp_window === 1'b1, "peer set");
    wr(6'h0C, 8'hD8);
    tick(2);
    check(forced_peer_gain_cut === 1'b0 && max_comp_window === 1'b0, "peer clear");
    pulse_gain();
    check(am_later_gain === 4'hA && pm_later_gain === 4'h3, "gain after restart");
    $display("test gain done");
  endtask
  task automatic t_default;
    wr(6'h0B, 8'h00);
    cmd_set_default <= 1'b1;
    tick(1);
    cmd_set_default <= 1'b0;
    for (int i = 0; i < 4; i++) rd(ofs[i], dflt[i]);
    $display("test default done");
  endtask
  task automatic t_sq(input logic [7:0] mt, input int lf, hf, ll, hl);
    int first;
    int last;
    first = 0;
    last = 0;
    mask_rx_time <= mt;
    fc_tick <= 1'b1;
    pulse_txend();
    check(rx_masked === 1'b1, "mask raised");
    for (int i = 1; i <= 60; i++) begin
      @(posedge clk_sys);
      #1;
      if (squelch_on === 1'b1 && first == 0) first = i;
      if (squelch_on === 1'b1) last = i;
    end
    check(rx_masked === 1'b0, "mask released");
    check(first >= lf && first <= hf && last >= ll && last <= hl, "squelch window");
    $display("test squelch done");
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst_b, reg_wr, reg_rd, cmd_set_default, cmd_reset_rx_gain, am_rx_on, pm_rx_on} = '0;
    {manual_chan_sel, single_mode, tx_end, fc_tick, reg_addr, reg_wdata, mask_rx_time} = '0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) rd(ofs[i], dflt[i]);
    check(agc_active === 1'b1, "agc after reset");
    t_rw();
    t_chan();
    t_gain();
    t_default();
    t_sq(8'h08, 8, 13, 28, 36);
    t_sq(8'h02, 0, 0, 0, 0);
    wr(6'h0B, 8'h18);
    tick(1);
    t_sq(8'h08, 0, 0, 0, 0);
    conclude();
  end
endmodule // rxcfg_regs_bench
